/* File: common/pcc_regs.vh */
// Constants for the extended power condition subcommand handler.
// Assumes inclusion by bare name from the rtl files.
`ifndef PCC_REGS_VH
`define PCC_REGS_VH

// ----------------------------------------
// Command decode
// ----------------------------------------
`define PCC_CMD_SET_FEATURES 8'hEF
`define PCC_FEAT_EPC 8'h4A
`define PCC_SUB_TIMER 4'h2
`define PCC_SUB_STATE 4'h3
`define PCC_SUB_ENABLE 4'h4

// ----------------------------------------
// Sector number field positions
// ----------------------------------------
`define PCC_SN_UNITS_BIT 7
`define PCC_SN_ENABLE_BIT 5
`define PCC_SN_SAVE_BIT 4

// ----------------------------------------
// Error and status bits
// ----------------------------------------
`define PCC_ERR_ABORT_BIT 2
`define PCC_ST_BUSY_BIT 7
`define PCC_ST_READY_BIT 6
`define PCC_ST_FAULT_BIT 5
`define PCC_ST_ERR_BIT 0
`define PCC_ERR_RESET 8'h00
`define PCC_STATUS_RESET 8'h40
`define PCC_IDW120_EPC_BIT 7

// ----------------------------------------
// Timer limits, 100 ms units
// ----------------------------------------
`define PCC_TIMER_MAX 24'h3BFFC4
`define PCC_TIMER_MIN 24'h000000
`define PCC_UNIT_MS 100
`define PCC_MINUTE_MS 60000
`define PCC_MINUTE_TICKS 24'h000258

`endif

/* File: rtl/pcc_timer_scale.v */
// Converts a 16-bit host timer value to clamped 100 ms units.
// Assumes purely combinational use inside the handler.
`timescale 1ns/1ps
`include "pcc_regs.vh"

module pcc_timer_scale (
    input wire [15:0] i_value,
    input wire i_minutes,
    output wire [23:0] o_ticks
);
    wire [31:0] scaled;
    wire [31:0] bounded;

    assign scaled = i_minutes ? ({16'h0000, i_value} * {8'h00, `PCC_MINUTE_TICKS})
                              : {16'h0000, i_value};
    assign bounded = (scaled > {8'h00, `PCC_TIMER_MAX}) ? {8'h00, `PCC_TIMER_MAX} :
                     (scaled < {8'h00, `PCC_TIMER_MIN}) ? {8'h00, `PCC_TIMER_MIN} : scaled;
    assign o_ticks = bounded[23:0];
endmodule

/* File: rtl/pcc_cond_timer.v */
// One power condition countdown timer in 100 ms ticks.
// Assumes a one-cycle tick strobe every 100 ms from the handler.
`timescale 1ns/1ps

module pcc_cond_timer (
    input wire i_clk_sys,
    input wire i_reset,
    input wire i_start,
    input wire i_stop,
    input wire i_tick,
    input wire [23:0] i_load,
    output reg o_expired
);
    reg [23:0] count_q;
    reg run_q;

    always @(posedge i_clk_sys) begin
        if (i_reset || i_stop) begin
            count_q <= 24'h000000;
            run_q <= 1'b0;
            o_expired <= 1'b0;
        end else if (i_start) begin
            count_q <= i_load;
            run_q <= 1'b1;
            o_expired <= 1'b0;
        end else if (run_q && i_tick) begin
            if (count_q <= 24'h000001) begin
                run_q <= 1'b0;
                o_expired <= 1'b1;
            end else begin
                count_q <= count_q - 24'h000001;
            end
        end
    end
endmodule

/* File: rtl/pcc_cmd_handler.v */
// Extended power condition subcommand handler of the feature command.
// Assumes the host presents the command block as a one-cycle strobe with
// its register values; the condition table is held here per condition id.
//
// How it works
// - Timer units 100 ms or 1 minute
// - Sector number bit 5 enables condition
// - Bit 4 saves settings, else untouched
// - Subcode 2h timer, 3h state, 4h enable
// - Clamp timer into minimum and maximum
// - Maximum 3BFFC4h, minimum zero
// - Timer aborts: disabled, unchangeable, unsavable
// - Abort leaves all settings unchanged
// - State sets current enable from bit
// - State save sets saved enable from same bit
// - State aborts: unchangeable, disabled, unsavable
// - Enable sets feature and identify bit
// - Enable turns advanced power management off
// - Current timer from default or saved
// - Start nonzero enabled timers after enable
// - Enabled feature survives all resets
// - Abort enable when feature unsupported
`timescale 1ns/1ps
`include "pcc_regs.vh"

module pcc_cmd_handler #(
    parameter NUM_COND = 4,
    parameter CLK_MHZ = 200,
    parameter TICK_CYCLES = `PCC_UNIT_MS * 1000 * CLK_MHZ,
    parameter [NUM_COND-1:0] COND_SUPPORTED = {NUM_COND{1'b1}},
    parameter [NUM_COND-1:0] COND_CHANGEABLE = {NUM_COND{1'b1}},
    parameter [NUM_COND-1:0] COND_SAVABLE = {NUM_COND{1'b1}},
    parameter [23:0] DEFAULT_TIMER = 24'h000064,
    parameter FEATURE_SUPPORTED = 1
) (
    input wire i_clk_sys,
    input wire i_reset,
    input wire i_cmd_valid,
    input wire [7:0] i_command,
    input wire [7:0] i_feature,
    input wire [7:0] i_sector_count,
    input wire [7:0] i_sector_number,
    input wire [7:0] i_cyl_low,
    input wire [7:0] i_cyl_high,
    output reg o_done,
    output reg [7:0] o_command_error_flags,
    output reg [7:0] o_command_status_flags,
    output reg o_extended_power_cond_set,
    output reg o_adv_power_mgmt_set,
    output reg o_idw120_epc,
    output reg [NUM_COND-1:0] o_cur_enabled,
    output reg [NUM_COND-1:0] o_saved_enabled,
    output reg [NUM_COND-1:0] o_timer_expired
);
    // ----------------------------------------
    // State and storage
    // ----------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_EXEC = 2'b01;
    localparam ST_START = 2'b10;

    reg [1:0] state_q;
    reg [7:0] cnt_q;
    reg [7:0] sn_q;
    reg [15:0] timer_in_q;
    reg [23:0] cur_timer_q [0:NUM_COND-1];
    reg [23:0] saved_timer_q [0:NUM_COND-1];
    reg [31:0] tick_cnt_q;
    reg tick_q;
    reg features_valid_q;

    wire [23:0] scaled_ticks;
    wire id_ok;
    wire [3:0] subcode;
    wire do_save;
    wire want_en;
    wire sel_change;
    wire sel_save_ok;
    wire [NUM_COND-1:0] start_vec;
    wire [NUM_COND-1:0] stop_vec;
    wire [NUM_COND-1:0] expired_vec;
    wire [NUM_COND-1:0] sel_vec;
    reg abort_d;
    reg start_pending_q;

    assign subcode = sn_q[3:0];
    assign do_save = sn_q[`PCC_SN_SAVE_BIT];
    assign want_en = sn_q[`PCC_SN_ENABLE_BIT];
    // Host places condition id in sector count
    assign id_ok = (cnt_q < NUM_COND);
    assign sel_change = id_ok && (|(sel_vec & COND_SUPPORTED & COND_CHANGEABLE));
    assign sel_save_ok = !do_save || (|(sel_vec & COND_SAVABLE));

    pcc_timer_scale u_scale (
        .i_value(timer_in_q),
        .i_minutes(sn_q[`PCC_SN_UNITS_BIT]),
        .o_ticks(scaled_ticks)
    );

    // ----------------------------------------
    // 100 ms tick
    // ----------------------------------------
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Abort decision
    // ----------------------------------------
    always @* begin
        abort_d = 1'b0;
        case (subcode)
            `PCC_SUB_TIMER: begin
                // Disabled feature, fixed or missing condition, unsavable
                abort_d = !o_extended_power_cond_set || !sel_change || !sel_save_ok;
            end
            `PCC_SUB_STATE: begin
                // Same three cases for the state form
                abort_d = !o_extended_power_cond_set || !sel_change || !sel_save_ok;
            end
            `PCC_SUB_ENABLE: begin
                abort_d = (FEATURE_SUPPORTED == 0);
            end
            default: begin
                // Subcodes outside this block are refused
                abort_d = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // Per condition timers and settings
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_COND; g = g + 1) begin : g_cond
            wire sel;
            wire timer_wr;
            wire state_wr;
            wire reload_wr;
            wire [23:0] reload_val;

            // One-hot pick of the addressed condition
            assign sel = (cnt_q == g);
            assign sel_vec[g] = sel;
            // Aborted commands raise none of these strobes
            assign timer_wr = (state_q == ST_EXEC) && !abort_d && sel &&
                              (subcode == `PCC_SUB_TIMER);
            assign state_wr = (state_q == ST_EXEC) && !abort_d && sel &&
                              (subcode == `PCC_SUB_STATE);
            assign reload_wr = (state_q == ST_EXEC) && !abort_d &&
                               (subcode == `PCC_SUB_ENABLE);
            // Zero saved timer falls back to default
            assign reload_val = (saved_timer_q[g] == 24'h000000) ?
                                DEFAULT_TIMER : saved_timer_q[g];

            always @(posedge i_clk_sys) begin
                if (i_reset) begin
                    cur_timer_q[g] <= 24'h000000;
                    saved_timer_q[g] <= 24'h000000;
                    o_cur_enabled[g] <= 1'b0;
                    o_saved_enabled[g] <= 1'b0;
                end else if (timer_wr) begin
                    cur_timer_q[g] <= scaled_ticks;
                    // Zero timer leaves the condition disabled
                    o_cur_enabled[g] <= want_en && (scaled_ticks != 24'h000000);
                    if (do_save) begin
                        saved_timer_q[g] <= scaled_ticks;
                        o_saved_enabled[g] <= want_en && (scaled_ticks != 24'h000000);
                    end
                end else if (state_wr) begin
                    o_cur_enabled[g] <= want_en;
                    if (do_save) begin
                        o_saved_enabled[g] <= want_en;
                    end
                end else if (reload_wr) begin
                    cur_timer_q[g] <= reload_val;
                end
            end

            // Start nonzero enabled timers only after a good enable
            assign start_vec[g] = (state_q == ST_START) && start_pending_q &&
                                  o_cur_enabled[g] && (cur_timer_q[g] != 24'h000000);
            assign stop_vec[g] = !o_cur_enabled[g];
            pcc_cond_timer u_tmr (
                .i_clk_sys(i_clk_sys),
                .i_reset(i_reset),
                .i_start(start_vec[g]),
                .i_stop(stop_vec[g]),
                .i_tick(tick_q),
                .i_load(cur_timer_q[g]),
                .o_expired(expired_vec[g])
            );
        end
    endgenerate

    // Remember a good enable for the start cycle
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            start_pending_q <= 1'b0;
        end else begin
            start_pending_q <= (state_q == ST_EXEC) && !abort_d &&
                               (subcode == `PCC_SUB_ENABLE);
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_timer_expired <= {NUM_COND{1'b0}};
        end else begin
            o_timer_expired <= expired_vec;
        end
    end

    // ----------------------------------------
    // Feature state kept across resets
    // ----------------------------------------
    // Power-on init only once; resets do not clear the feature
    always @(posedge i_clk_sys) begin
        if (!features_valid_q) begin
            features_valid_q <= 1'b1;
            o_extended_power_cond_set <= 1'b0;
            o_idw120_epc <= 1'b0;
            o_adv_power_mgmt_set <= 1'b1;
        end else if (state_q == ST_EXEC && subcode == `PCC_SUB_ENABLE && FEATURE_SUPPORTED) begin
            o_extended_power_cond_set <= 1'b1;
            o_idw120_epc <= 1'b1;
            o_adv_power_mgmt_set <= 1'b0;
        end
    end

    initial features_valid_q = 1'b0;

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            sn_q <= 8'h00;
            timer_in_q <= 16'h0000;
            o_done <= 1'b0;
            o_command_error_flags <= `PCC_ERR_RESET;
            o_command_status_flags <= `PCC_STATUS_RESET;
        end else begin
            o_done <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Only feature 4Ah under command EFh is ours
                    if (i_cmd_valid && i_command == `PCC_CMD_SET_FEATURES &&
                        i_feature == `PCC_FEAT_EPC) begin
                        cnt_q <= i_sector_count;
                        sn_q <= i_sector_number;
                        timer_in_q <= {i_cyl_high, i_cyl_low};
                        o_command_status_flags <= 8'h80;
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    o_done <= 1'b1;
                    state_q <= ST_START;
                    o_command_error_flags <= `PCC_ERR_RESET;
                    o_command_status_flags <= `PCC_STATUS_RESET;
                    case (subcode)
                        `PCC_SUB_TIMER, `PCC_SUB_STATE: begin
                            if (!o_extended_power_cond_set || !sel_change || !sel_save_ok) begin
                                o_command_error_flags[`PCC_ERR_ABORT_BIT] <= 1'b1;
                                o_command_status_flags[`PCC_ST_ERR_BIT] <= 1'b1;
                            end
                        end
                        `PCC_SUB_ENABLE: begin
                            if (!FEATURE_SUPPORTED) begin
                                o_command_error_flags[`PCC_ERR_ABORT_BIT] <= 1'b1;
                                o_command_status_flags[`PCC_ST_ERR_BIT] <= 1'b1;
                            end
                        end
                        default: begin
                            o_command_error_flags[`PCC_ERR_ABORT_BIT] <= 1'b1;
                            o_command_status_flags[`PCC_ST_ERR_BIT] <= 1'b1;
                        end
                    endcase
                end
                ST_START: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: test/pcc_cmd_handler_sva.sv */
// Port-level checks for the power condition command handler.
// Assumes it is bound onto every pcc_cmd_handler with its NUM_COND.
`timescale 1ns/1ps
module pcc_cmd_handler_sva #(
    parameter NUM_COND = 4
) (
    input wire i_clk_sys,
    input wire i_reset,
    input wire i_cmd_valid,
    input wire [7:0] i_command,
    input wire [7:0] i_feature,
    input wire o_done,
    input wire [7:0] o_command_error_flags,
    input wire [7:0] o_command_status_flags,
    input wire o_extended_power_cond_set,
    input wire o_adv_power_mgmt_set,
    input wire o_idw120_epc,
    input wire [NUM_COND-1:0] o_cur_enabled,
    input wire [NUM_COND-1:0] o_saved_enabled
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    // ----------------------------------------
    // Command take and answer
    // ----------------------------------------
    sequence take_s;
        i_cmd_valid && i_command == 8'hEF && i_feature == 8'h4A
            && !o_command_status_flags[7] && !o_done;
    endsequence
    sequence answer_s;
        o_command_status_flags[7] ##1 o_done;
    endsequence
    take_done_a: assert property (take_s |-> ##1 answer_s)
        else $error("command not answered in time");
    decode_only_a: assert property ($rose(o_command_status_flags[7]) |->
        $past(i_cmd_valid && i_command == 8'hEF && i_feature == 8'h4A))
        else $error("busy without a valid command");
    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    abort_flag_a: assert property (o_done |->
        o_command_error_flags[2] == o_command_status_flags[0])
        else $error("abort and error bits disagree");
    done_status_a: assert property (o_done |-> o_command_status_flags[7:5] == 3'h2)
        else $error("bad status at completion");
    abort_keep_a: assert property (o_done && o_command_error_flags[2] |->
        $stable(o_cur_enabled) && $stable(o_saved_enabled)
        && $stable(o_extended_power_cond_set))
        else $error("aborted command changed settings");
    enable_side_a: assert property ($rose(o_extended_power_cond_set) |->
        o_idw120_epc && !o_adv_power_mgmt_set)
        else $error("enable side effects missing");
    idw_track_a: assert property (o_idw120_epc == o_extended_power_cond_set)
        else $error("identify bit differs from feature");
    epc_hold_a: assert property (o_extended_power_cond_set |=> o_extended_power_cond_set)
        else $error("feature dropped");
    saved_move_a: assert property (!$stable(o_saved_enabled) |-> o_done)
        else $error("saved flags moved outside completion");
endmodule

bind pcc_cmd_handler pcc_cmd_handler_sva #(.NUM_COND(NUM_COND)) pcc_cmd_handler_sva_i (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
    .i_command(i_command), .i_feature(i_feature), .o_done(o_done),
    .o_command_error_flags(o_command_error_flags),
    .o_command_status_flags(o_command_status_flags),
    .o_extended_power_cond_set(o_extended_power_cond_set),
    .o_adv_power_mgmt_set(o_adv_power_mgmt_set), .o_idw120_epc(o_idw120_epc),
    .o_cur_enabled(o_cur_enabled), .o_saved_enabled(o_saved_enabled));

/* File: test/pcc_host_model.sv */
// Host side model that issues feature subcommands on the command block.
// Assumes the handler samples the block on the edge where valid is high.
`timescale 1ns/1ps
module pcc_host_model (
    input wire i_clk_sys,
    output logic o_cmd_valid,
    output logic [7:0] o_command,
    output logic [7:0] o_feature,
    output logic [7:0] o_sector_count,
    output logic [7:0] o_sector_number,
    output logic [15:0] o_timer
);
    logic [47:0] blk = 48'h0;
    initial o_cmd_valid = 1'b0;
    assign {o_command, o_feature, o_sector_count, o_sector_number, o_timer} = blk;
    // ----------------------------------------
    // One command, then released lines invert
    // ----------------------------------------
    task automatic issue(input logic [7:0] f, c, s, input logic [15:0] t, input int gap);
        @(posedge i_clk_sys);
        #1;
        blk = {8'hEF, f, c, s, t};
        o_cmd_valid = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_cmd_valid = 1'b0;
        blk = ~blk;
        repeat (gap) @(posedge i_clk_sys);
    endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the power condition command handler.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_top;
    logic i_clk_sys, i_reset, cmd_valid, done, extended_power_cond_set, adv_power_mgmt_set, idw, e_epc, e_apm;
    logic [7:0] command, feature, sc, sn, err, status;
    logic [15:0] tmr;
    logic [3:0] cur, saved, expired, e_cur, e_saved;
    logic [26:0] exp_q[$];
    int fail_count = 0;
    int checks = 0;
    int n;
    pcc_cmd_handler #(.TICK_CYCLES(10), .COND_SAVABLE(4'hB)) pcc_cmd_handler_i (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cmd_valid(cmd_valid),
        .i_command(command), .i_feature(feature), .i_sector_count(sc),
        .i_sector_number(sn), .i_cyl_low(tmr[7:0]), .i_cyl_high(tmr[15:8]),
        .o_done(done), .o_command_error_flags(err), .o_command_status_flags(status),
        .o_extended_power_cond_set(extended_power_cond_set), .o_adv_power_mgmt_set(adv_power_mgmt_set), .o_idw120_epc(idw),
        .o_cur_enabled(cur), .o_saved_enabled(saved), .o_timer_expired(expired));
    pcc_host_model pcc_host_model_i (
        .i_clk_sys(i_clk_sys), .o_cmd_valid(cmd_valid), .o_command(command),
        .o_feature(feature), .o_sector_count(sc), .o_sector_number(sn), .o_timer(tmr));
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    // ----------------------------------------
    // Compare, verdict and command helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [26:0] want(input logic ab);
        return {5'h0, ab, 2'h0, 7'h20, ab, e_epc, e_apm, e_epc, e_cur, e_saved};
    endfunction
    task automatic send(input logic [7:0] f, c, s, input logic [15:0] t, input logic ab);
        if (f == 8'h4A) exp_q.push_back(want(ab));
        pcc_host_model_i.issue(f, c, s, t, 2);
        for (n = 0; n < 20 && exp_q.size() != 0; n++) @(posedge i_clk_sys);
        if (exp_q.size() != 0) begin
            fail_count++;
            end_sim();
        end
    endtask
    always @(posedge i_clk_sys) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check({err, status, extended_power_cond_set, adv_power_mgmt_set, idw, cur, saved}, exp_q.pop_front());
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        i_reset = 1'b1;
        void'($urandom(32'h8CDC6E7D));
        repeat (20) @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        {e_epc, e_apm, e_cur, e_saved} = 10'h100;
        check({err, status, extended_power_cond_set, adv_power_mgmt_set, idw}, {16'h0040, 3'h2});
        send(8'h4A, 8'h00, 8'h32, 16'h0001, 1'b1);
        send(8'h4A, 8'h01, 8'h23, 16'h0000, 1'b1);
        send(8'h4B, 8'h01, 8'h04, 16'h0000, 1'b0);
        send(8'h4A, 8'h00, 8'h06, 16'h0000, 1'b1);
        {e_epc, e_apm} = 2'h2;
        send(8'h4A, 8'h00, 8'h04, 16'h0000, 1'b0);
        {e_cur, e_saved} = 8'h11;
        send(8'h4A, 8'h00, 8'h32, 16'h0001, 1'b0);
        {e_cur, e_saved} = 8'h31;
        send(8'h4A, 8'h01, 8'h23, 16'h0000, 1'b0);
        {e_cur, e_saved} = 8'h11;
        send(8'h4A, 8'h01, 8'h22, 16'h0000, 1'b0);
        send(8'h4A, 8'h04, 8'h23, 16'h0000, 1'b1);
        send(8'h4A, 8'h05, 8'h32, 16'h0005, 1'b1);
        {e_cur, e_saved} = 8'h00;
        send(8'h4A, 8'h00, 8'h13, 16'h0000, 1'b0);
        {e_cur, e_saved} = 8'h11;
        send(8'h4A, 8'h00, 8'h33, 16'h0000, 1'b0);
        {e_cur, e_saved} = 8'h99;
        send(8'h4A, 8'h03, 8'hB2, 16'(($urandom % 16'hFFFF) + 1), 1'b0);
        {e_cur, e_saved} = 8'hD9;
        send(8'h4A, 8'h02, 8'hA2, 16'hFFFF, 1'b0);
        send(8'h4A, 8'h02, 8'h32, 16'h0007, 1'b1);
        send(8'h4A, 8'h02, 8'h33, 16'h0000, 1'b1);
        send(8'h4A, 8'h00, 8'h04, 16'h0000, 1'b0);
        for (n = 0; n < 60 && expired[0] !== 1'b1; n++) @(posedge i_clk_sys);
        check(expired, 4'h1);
        for (n = 0; n < 1100 && expired[2] !== 1'b1; n++) @(posedge i_clk_sys);
        check(expired, 4'h5);
        check(n > 900, 1'b1);
        #1 i_reset = 1'b1;
        repeat (20) @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        check({extended_power_cond_set, adv_power_mgmt_set, idw, err, status}, {3'h5, 16'h0040});
        end_sim();
    end
endmodule
